// ### tmr_defines.svh
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_COUNT      12'h000
`define ADDR_OPTION     12'h004
`define ADDR_INTCTL     12'h008
`define ADDR_CAPSENSE   12'h00C
`define ADDR_WDT_STATUS 12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OPT_CS_BIT      5
`define OPT_SE_BIT      4
`define OPT_PSA_BIT     3
`define INT_IE_BIT      5
`define INT_IF_BIT      2
`define CAP_XCS_BIT     0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OPTION_RESET    8'hFF
`define INTCTL_RESET    8'h00
`define CAPSENSE_RESET  8'h00
`define COUNT_RESET     8'h00

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define CORE_CLK_HZ     40000000
`define INSTR_CLK_HZ    10000000
`define QUARTERS        (`CORE_CLK_HZ / `INSTR_CLK_HZ)
`define WRITE_INHIBIT   2

`endif

// ### tmr_pkg.sv
package tmr_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        src_instr,
        src_pin,
        src_caposc
    } source_t;
endpackage : tmr_pkg

// ### tmr_core.sv
// Contract
// - Timer mode counts each instruction cycle
// - Count write inhibits two instruction cycles
// - Counter mode counts chosen input edges
// - Source one, external zero: count pin
// - Both selects one: count capacitive oscillator
// - Edge select chooses counted transition
// - Edge one falling, zero rising
// - Edge sampled in Q2 and Q4
// - One prescaler, timer when assignment zero
// - Eight timer ratios, 1:2 to 1:256
// - Codes give timer and watchdog ratios
// - Timer 1:1 only with watchdog assignment
// - Prescaler hidden; count write clears it when assigned to timer (not while sleep_mode is high, where the prescaler holds)
// - Watchdog clear clears prescaler when assigned to watchdog (not while sleep_mode is high, where the prescaler holds)
// - Interrupt on FFh to 00h rollover
// - Flag set regardless of enable
// - Flag cleared only by software
// - Request forwarded only when enabled
// - Counter frozen during sleep
//
// The APB slave port and the register addresses were chosen for this implementation.
`include "tmr_defines.svh"

module tmr_core (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  external_count_pin,
    input  wire logic                  capacitive_sense_oscillator,
    input  wire logic                  sleep_mode,
    input  wire logic                  watchdog_clear_instruction,
    output logic                       overflow_irq,
    output logic                       watchdog_tick
);
    import tmr_pkg::*;

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    tmr_pkg::byte_t count_reg;
    tmr_pkg::byte_t option_reg;
    tmr_pkg::byte_t intctl_reg;
    tmr_pkg::byte_t capsense_reg;
    tmr_pkg::byte_t prescale_reg;
    logic [1:0]     phase_reg;
    logic [1:0]     inhibit_reg;
    logic           pin_s1_reg;
    logic           pin_s2_reg;
    logic           osc_s1_reg;
    logic           osc_s2_reg;
    logic           edge_prev_reg;
    logic           wdt_clk_reg;

    // ----------------------------------------
    // Decoded controls
    // ----------------------------------------
    logic           clock_source_select;
    logic           external_source_select;
    logic           edge_select;
    logic           prescaler_assignment;
    logic [2:0]     prescale_rate_field;
    logic           overflow_interrupt_enable;
    logic           overflow_flag;
    source_t        src;
    logic           instr_tick;
    logic           q_sample;
    logic           raw_in;
    logic           edge_tick;
    logic           source_tick;
    logic           pre_tick;
    logic           pre_out;
    logic           count_tick;
    logic           wr_access;
    logic           rd_access;
    logic           wr_count;
    logic           wr_intctl;
    logic           rollover;
    logic [7:0]     prescale_next;
    logic           wdt_pre_tick;

    assign clock_source_select       = option_reg[`OPT_CS_BIT];
    assign edge_select               = option_reg[`OPT_SE_BIT];
    assign prescaler_assignment      = option_reg[`OPT_PSA_BIT];
    assign prescale_rate_field       = option_reg[2:0];
    assign external_source_select    = capsense_reg[`CAP_XCS_BIT];
    assign overflow_interrupt_enable = intctl_reg[`INT_IE_BIT];
    assign overflow_flag             = intctl_reg[`INT_IF_BIT];

    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign wr_count  = wr_access && (paddr == `ADDR_COUNT);
    assign wr_intctl = wr_access && (paddr == `ADDR_INTCTL);

    // ----------------------------------------
    // Instruction clock quarter phases
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    assign instr_tick = (phase_reg == 2'(`QUARTERS - 1));
    assign q_sample   = phase_reg[0];  // Q2 and Q4

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
        end else begin
            pin_s1_reg <= external_count_pin;
            pin_s2_reg <= pin_s1_reg;
            osc_s1_reg <= capacitive_sense_oscillator;
            osc_s2_reg <= osc_s1_reg;
        end
    end

    // ----------------------------------------
    // Source selection and edge detect
    // ----------------------------------------
    always_comb begin
        if (!clock_source_select) begin
            src = src_instr;
        end else if (!external_source_select) begin
            src = src_pin;
        end else begin
            src = src_caposc;
        end
    end

    always_comb begin
        case (src)
            src_pin: begin
                raw_in = pin_s2_reg;
            end
            src_caposc: begin
                raw_in = osc_s2_reg;
            end
            default: begin
                raw_in = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            edge_prev_reg <= 1'b0;
        end else if (q_sample) begin
            edge_prev_reg <= raw_in;
        end
    end

    // Level compare, so reset or an edge-select change fakes no edge
    assign edge_tick   = q_sample && (edge_select ? (edge_prev_reg && !raw_in)
                                                  : (raw_in && !edge_prev_reg));
    assign source_tick = (src == src_instr) ? instr_tick : edge_tick;

    // ----------------------------------------
    // Shared prescaler
    // ----------------------------------------
    assign wdt_pre_tick = watchdog_clear_instruction ? 1'b0 : instr_tick;
    assign pre_tick     = prescaler_assignment ? wdt_pre_tick : source_tick;
    assign prescale_next = prescale_reg + 8'h01;
    // Ratio is 2^(code+1) for timer, 2^code for watchdog
    assign pre_out = pre_tick && (prescaler_assignment ?
                     ((prescale_reg & ((8'h01 << prescale_rate_field) - 8'h01)) ==
                      ((8'h01 << prescale_rate_field) - 8'h01)) :
                     ((prescale_next & ((8'h02 << prescale_rate_field) - 8'h01)) == 8'h00));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prescale_reg <= 8'h00;
        end else if (sleep_mode) begin
            prescale_reg <= prescale_reg;
        end else if (!prescaler_assignment && wr_count) begin
            prescale_reg <= 8'h00;
        end else if (prescaler_assignment && watchdog_clear_instruction) begin
            prescale_reg <= 8'h00;
        end else if (pre_tick) begin
            prescale_reg <= prescale_next;
        end
    end

    // Timer sees 1:1 only when prescaler belongs to watchdog
    assign count_tick = prescaler_assignment ? source_tick : pre_out;

    // ----------------------------------------
    // Watchdog tick output
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wdt_clk_reg <= 1'b0;
        end else begin
            wdt_clk_reg <= prescaler_assignment ? (pre_out && !sleep_mode) : instr_tick;
        end
    end

    // ----------------------------------------
    // Count register
    // ----------------------------------------
    assign rollover = count_tick && !sleep_mode && (inhibit_reg == 2'h0) && (count_reg == 8'hFF);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            inhibit_reg <= 2'h0;
        end else if (wr_count) begin
            inhibit_reg <= 2'(`WRITE_INHIBIT);
        end else if (instr_tick && inhibit_reg != 2'h0) begin
            inhibit_reg <= inhibit_reg - 2'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count_reg <= `COUNT_RESET;
        end else if (wr_count) begin
            count_reg <= pwdata[7:0];
        end else if (sleep_mode) begin
            count_reg <= count_reg;
        end else if (count_tick && inhibit_reg == 2'h0) begin
            count_reg <= count_reg + 8'h01;  // wraps to zero
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            option_reg   <= `OPTION_RESET;
            capsense_reg <= `CAPSENSE_RESET;
        end else if (wr_access) begin
            if (paddr == `ADDR_OPTION) begin
                option_reg <= pwdata[7:0];
            end
            if (paddr == `ADDR_CAPSENSE) begin
                capsense_reg <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            intctl_reg <= `INTCTL_RESET;
        end else begin
            if (wr_intctl) begin
                intctl_reg <= pwdata[7:0];
            end
            if (rollover) begin
                intctl_reg[`INT_IF_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            overflow_irq <= 1'b0;
        end else begin
            overflow_irq <= overflow_flag && overflow_interrupt_enable;
        end
    end

    assign watchdog_tick = wdt_clk_reg;

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    `ADDR_COUNT:    prdata <= {24'h000000, count_reg};
                    `ADDR_OPTION:   prdata <= {24'h000000, option_reg};
                    `ADDR_INTCTL:   prdata <= {24'h000000, intctl_reg};
                    `ADDR_CAPSENSE: prdata <= {24'h000000, capsense_reg};
                    default: begin
                        prdata  <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule : tmr_core

// ### edge_source.sv
// ----------------------------------------
// Count input source
// ----------------------------------------
module edge_source (
    input  wire logic       core_clk,
    input  wire logic       go,
    input  wire logic       sel,
    input  wire logic [4:0] half,
    output logic            external_count_pin,
    output logic            capacitive_sense_oscillator
);
    logic [4:0] cnt_reg;

    initial begin
        cnt_reg = 5'h00;
        external_count_pin = 1'b0;
        capacitive_sense_oscillator = 1'b0;
    end

    // Toggles the chosen line every half+1 cycles, still otherwise
    always @(posedge core_clk) begin
        cnt_reg <= (go && cnt_reg != half) ? cnt_reg + 5'h01 : 5'h00;
        if (go && cnt_reg == half && !sel) begin
            external_count_pin <= !external_count_pin;
        end
        if (go && cnt_reg == half && sel) begin
            capacitive_sense_oscillator <= !capacitive_sense_oscillator;
        end
    end
endmodule : edge_source

// ### tmr_core_assertions.sv
`include "tmr_defines.svh"

module tmr_core_checker (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_mode,
    input wire logic        overflow_irq,
    input wire logic        watchdog_tick
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic ctl_wr;
    assign ctl_wr = psel && penable && pwrite && paddr == `ADDR_INTCTL;

    AST_PREADY_SETUP: assert property (psel && !penable |=> pready) else $error("no answer");
    AST_PREADY_CAUSE: assert property (pready |-> $past(psel && !penable)) else $error("stray pready");
    AST_PREADY_PULSE: assert property (pready |=> !pready) else $error("long pready");
    AST_SLVERR_MAP: assert property (psel && !penable && paddr > `ADDR_CAPSENSE |=> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    AST_IRQ_DISABLE:
        assert property (ctl_wr && !pwdata[`INT_IE_BIT] |-> ##2 !overflow_irq) else $error("irq while disabled");
    AST_IRQ_FALL:
        assert property ($fell(overflow_irq) |-> $past(ctl_wr, 2)) else $error("irq fell by itself");
    AST_SLEEP_FROZEN:
        assert property (sleep_mode && $past(sleep_mode) && $past(sleep_mode, 2) && !$past(ctl_wr)
            |=> $stable(overflow_irq)) else $error("irq moved in sleep");
    AST_WDT_PULSE:
        assert property (watchdog_tick |=> !watchdog_tick [*3]) else $error("tick too close");
endmodule : tmr_core_checker

bind tmr_core tmr_core_checker tmr_core_checker_i (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .overflow_irq(overflow_irq), .watchdog_tick(watchdog_tick));

// ### eight_bit_timer_counter_prescaler_test.sv
`include "tmr_defines.svh"

module eight_bit_timer_counter_prescaler_test;
    timeunit 1ns;
    timeprecision 100ps;
    import tmr_pkg::*;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_pin;
    logic        cap_osc;
    logic        sleep_mode = 1'b0;
    logic        wdt_clear = 1'b0;
    logic        overflow_irq;
    logic        watchdog_tick;
    logic        go = 1'b0;
    logic        sel = 1'b0;
    logic [4:0]  half = 5'h08;
    logic        re;
    byte_t       rq;
    byte_t       c0;
    byte_t       x;
    int          fail_count = 0;
    int          num_checks = 0;
    int          sum;
    int          n;
    int          h;

    always #12.5 core_clk = !core_clk;

    tmr_core tmr_core_i (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_pin(ext_pin), .capacitive_sense_oscillator(cap_osc), .sleep_mode(sleep_mode),
        .watchdog_clear_instruction(wdt_clear), .overflow_irq(overflow_irq), .watchdog_tick(watchdog_tick));
    edge_source edge_source_i (.core_clk(core_clk), .go(go), .sel(sel), .half(half),
        .external_count_pin(ext_pin), .capacitive_sense_oscillator(cap_osc));

    // ----------------------------------------
    // Bus, compare and closing tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input byte_t d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rq = prdata[7:0];
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check(input string what, input byte_t seen, input byte_t exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic count_ticks(input int cycles);
        n = 0;
        repeat (cycles) begin
            @(posedge core_clk);
            n += int'(watchdog_tick === 1'b1);
        end
    endtask : count_ticks

    function automatic int ratio(input int k);
        return k < 8 ? 2 << k : 1;
    endfunction : ratio

    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (40000) @(posedge core_clk);
        fail_count++;
        close_out();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        void'($urandom(48247));
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 12'(4 * k), 8'h00);
            check("reset value", rq, k == 1 ? `OPTION_RESET : 8'h00);
            check("slave error", {7'h0, re}, {7'h0, 1'(k == 4)});
        end
        for (int k = 0; k < 9; k++) begin
            apb(1'b1, `ADDR_OPTION, k < 8 ? 8'(k) : 8'h08);
            repeat ($urandom_range(0, 7)) @(posedge core_clk);
            apb(1'b0, `ADDR_COUNT, 8'h00);
            c0 = rq;
            repeat (12 * ratio(k) - 3) @(posedge core_clk);
            apb(1'b0, `ADDR_COUNT, 8'h00);
            check("count step", rq - c0, 8'h03);
        end
        apb(1'b1, `ADDR_OPTION, 8'h07);
        repeat ($urandom_range(0, 255)) @(posedge core_clk);
        apb(1'b1, `ADDR_COUNT, 8'h00);
        repeat (1000) @(posedge core_clk);
        apb(1'b0, `ADDR_COUNT, 8'h00);
        check("prescaler cleared early", rq, 8'h00);
        repeat (20) @(posedge core_clk);
        apb(1'b0, `ADDR_COUNT, 8'h00);
        check("prescaler cleared late", rq, 8'h01);
        apb(1'b1, `ADDR_OPTION, 8'h08);
        sum = 0;
        for (int p = 0; p < 4; p++) begin
            x = 8'($urandom_range(0, 127));
            apb(1'b1, `ADDR_COUNT, x);
            repeat (37) @(posedge core_clk);
            apb(1'b0, `ADDR_COUNT, 8'h00);
            sum += int'(byte_t'(rq - x));
            repeat (2) @(posedge core_clk);
        end
        check("inhibit window", 8'(sum > 27 && sum < 33), 8'h01);
        apb(1'b1, `ADDR_COUNT, 8'hF0);
        repeat (100) @(posedge core_clk);
        apb(1'b0, `ADDR_INTCTL, 8'h00);
        check("flag set", rq, 8'h04);
        check("irq masked", {7'h0, overflow_irq}, 8'h00);
        apb(1'b0, `ADDR_COUNT, 8'h00);
        check("count wrapped", 8'(rq < 8'h10 && rq > 8'h00), 8'h01);
        apb(1'b1, `ADDR_INTCTL, 8'h24);
        repeat (2) @(posedge core_clk);
        check("irq raised", {7'h0, overflow_irq}, 8'h01);
        apb(1'b1, `ADDR_INTCTL, 8'h20);
        repeat (2) @(posedge core_clk);
        check("irq cleared", {7'h0, overflow_irq}, 8'h00);
        sleep_mode <= 1'b1;
        repeat (8) @(posedge core_clk);
        apb(1'b0, `ADDR_COUNT, 8'h00);
        c0 = rq;
        repeat (100) @(posedge core_clk);
        apb(1'b0, `ADDR_COUNT, 8'h00);
        check("frozen", rq, c0);
        sleep_mode <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            apb(1'b1, `ADDR_CAPSENSE, {7'h0, 1'(k == 2 || k == 3)});
            apb(1'b1, `ADDR_OPTION, {3'h1, 1'(k % 2), 4'h8});
            apb(1'b0, `ADDR_COUNT, 8'h00);
            c0 = rq;
            h = $urandom_range(8, 20);
            half <= 5'(h);
            sel <= k > 1;
            go <= 1'b1;
            repeat ((k < 4 ? 5 : 4) * (h + 1)) @(posedge core_clk);
            go <= 1'b0;
            repeat (12) @(posedge core_clk);
            apb(1'b0, `ADDR_COUNT, 8'h00);
            check("edges counted", rq - c0, k < 4 ? 8'h03 : 8'h00);
        end
        apb(1'b1, `ADDR_OPTION, 8'h0F);
        repeat (600) @(posedge core_clk);
        wdt_clear <= 1'b1;
        @(posedge core_clk);
        wdt_clear <= 1'b0;
        count_ticks(480);
        check("quiet after clear", 8'(n), 8'h00);
        count_ticks(64);
        check("tick after clear", 8'(n), 8'h01);
        close_out();
    end
endmodule : eight_bit_timer_counter_prescaler_test
